// [inc/fpc_cfg.svh]
/*
 constants of the flash prefetch read controller: timing, address map, bus codes.
 assumes a single system clock at FPC_CLK_MHZ and an array that answers a read
 in the last of its wait-state cycles.
*/
// Behaviour
// RL1: Bus accesses arrive on a 64-bit system port and the array is read through a 128-bit interface.
// RL2: Four line buffers each hold one 128-bit flash line so reads can be served without the array.
// RL3: A read that hits a line buffer completes with no wait states.
// RL4: A read that misses all buffers inserts three wait states when the clock runs at 120 MHz.
// RL5: The array access uses two wait states up to 80 MHz and one wait state up to 60 MHz.
// RL6: Each 128-bit line carries an 8-bit check code per 64-bit word, 144 stored bits in all.
// RL7: Reads correct any single-bit error in a protected word and detect any double-bit error.
// RL8: The array interface has a 128-bit read data bus and a separate 64-bit write data bus.
// RL9: Aligned and unaligned reads are served when the bytes lie within one 32-bit container.
// RL10: Bus masters issue only naturally aligned 32-bit word writes.
// RL11: On the code bank only, read buffering and page prefetch are each enabled by a setting.
// RL12: With prefetch enabled the next flash line is read speculatively into a line buffer.
// RL13: The array holds 1 MB in several partitions of one macro.
// RL14: A 16 KB test sector and a 16 KB shadow block exist besides the main array.
// RL15: An uncorrectable read error ends the transfer with a bus error and sets a clearable sticky flag.
// RL16: A new line replaces the least recently used buffer and any array write invalidates every buffer.
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
`define FPC_CLK_MHZ      25
`define FPC_ARR_WS       (((`FPC_CLK_MHZ) <= 60) ? 1 : (((`FPC_CLK_MHZ) <= 80) ? 2 : 3))
`define FPC_NBUF         4
`define FPC_LINE_W       128
`define FPC_WORD_W       64
`define FPC_CW_W         72
`define FPC_ROW_W        144
`define FPC_LIDX_W       16
`define FPC_MAIN_SEL_BIT 20
`define FPC_SUB_SEL_BIT  14
`define FPC_LINE_LSB     4
`define FPC_DW_BIT       3
`define FPC_RGN_MAIN     2'h0
`define FPC_RGN_TEST     2'h1
`define FPC_RGN_SHADOW   2'h2
`define FPC_LAST_LINE    16'hFFFF
`define FPC_SZ_BYTE      3'h0
`define FPC_SZ_HALF      3'h1
`define FPC_SZ_WORD      3'h2
`endif

// [inc/fpc_pkg.sv]
/*
 types of the flash prefetch read controller.
 assumes fpc_cfg.svh supplies the word and line-index widths.
*/
`include "fpc_cfg.svh"
package fpc_pkg;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_FETCH = 7'h02,
      ST_PREF  = 7'h04,
      ST_CHECK = 7'h08,
      ST_WRITE = 7'h10,
      ST_ERR1  = 7'h20,
      ST_ERR2  = 7'h40
   } fpc_state_t;
   typedef struct packed {
      logic [1:0]               rgn;
      logic [`FPC_LIDX_W-1:0]   line;
   } fpc_tag_t;
   typedef struct packed {
      logic [31:0]              addr;
      logic [2:0]               size;
      logic                     write;
   } fpc_req_t;
   typedef struct packed {
      logic                     req;
      fpc_tag_t                 tag;
   } fpc_rd_t;
   typedef struct packed {
      logic                     en;
      fpc_tag_t                 tag;
      logic                     dword;
      logic [1:0]               wmask;
      logic [`FPC_WORD_W-1:0]   data;
   } fpc_wr_t;
   typedef struct packed {
      logic [`FPC_WORD_W-1:0]   data;
      logic                     sbe;
      logic                     dbe;
   } fpc_ecc_t;
endpackage

// [rtl/fpc_ctrl.sv]
/*
 flash prefetch read controller: ahb-lite slave, four line buffers with lru
 replacement and next-line prefetch, secded check on every 64-bit word read.
 assumes the array returns a 144-bit row on arr_rd_data_in in the last wait
 cycle of a read, and computes its own check bits when written.
*/
`timescale 1ns/10ps
`include "fpc_cfg.svh"
module fpc_ctrl (
   // clock and reset
   input  wire logic                      core_clk_in,
   input  wire logic                      srst_in,
   // ahb-lite slave
   input  wire logic                      hsel_in,
   input  wire logic [31:0]               haddr_in,
   input  wire logic [1:0]                htrans_in,
   input  wire logic                      hwrite_in,
   input  wire logic [2:0]                hsize_in,
   input  wire logic [`FPC_WORD_W-1:0]    hwdata_in,
   input  wire logic                      hready_in,
   output logic      [`FPC_WORD_W-1:0]    hrdata_out,
   output logic                           hreadyout_out,
   output logic                           hresp_out,
   // configuration and status
   input  wire logic                      cfg_buf_en_in,
   input  wire logic                      cfg_pf_en_in,
   input  wire logic                      ecc_err_clr_in,
   output logic                           ecc_err_out,
   output logic                           ecc_corr_out,
   // nonvolatile_array interface
   output fpc_pkg::fpc_rd_t               arr_rd_out,
   input  wire logic [`FPC_ROW_W-1:0]     arr_rd_data_in,
   output fpc_pkg::fpc_wr_t               arr_wr_out
);
   localparam logic [1:0] WS = 2'(`FPC_ARR_WS); // RL4 RL5

   // secded over 64 data bits; check bits 6:0 at hamming positions, bit 7 overall parity
   function automatic fpc_pkg::fpc_ecc_t ecc_dec(input logic [`FPC_CW_W-1:0] cw);
      logic [6:0]       syn;
      logic             par;
      int               j;
      fpc_pkg::fpc_ecc_t r;
      syn = cw[70:64];
      par = ^cw;
      r.data = cw[63:0];
      j = 0;
      for (int p = 1; p < `FPC_CW_W; p++)
         if ((p & (p - 1)) != 0)
         begin
            if (cw[j])
               syn = syn ^ 7'(p);
            j++;
         end
      j = 0;
      for (int p = 1; p < `FPC_CW_W; p++)
         if ((p & (p - 1)) != 0)
         begin
            if (par && (syn == 7'(p)))
               r.data[j] = ~r.data[j]; // RL7
            j++;
         end
      r.sbe = par;
      r.dbe = !par && (syn != 7'h00); // RL7
      return r;
   endfunction

   fpc_pkg::fpc_state_t            state_q, state_d;
   fpc_pkg::fpc_req_t              req_q, cur;
   fpc_pkg::fpc_rd_t               rd_q;
   fpc_pkg::fpc_wr_t               wr_q;
   fpc_pkg::fpc_tag_t              lk_tag, pf_tag_q, nxt_tag;
   fpc_pkg::fpc_ecc_t              dec0, dec1;
   logic [`FPC_NBUF-1:0]           vld_q, hit, pf_hitv;
   fpc_pkg::fpc_tag_t              tag_q  [`FPC_NBUF];
   logic [`FPC_LINE_W-1:0]         data_q [`FPC_NBUF];
   logic [1:0]                     age_q  [`FPC_NBUF];
   logic [`FPC_LINE_W-1:0]         hit_or [`FPC_NBUF+1];
   logic [1:0]                     cnt_q, hit_idx, vic_idx, touch_idx;
   logic [`FPC_WORD_W-1:0]         hrdata_q;
   logic [`FPC_LINE_W-1:0]         row;
   logic                           pend_q, pf_q, err_q, corr_q;

   wire st_idle  = state_q == fpc_pkg::ST_IDLE;
   wire st_fetch = state_q == fpc_pkg::ST_FETCH;
   wire st_pref  = state_q == fpc_pkg::ST_PREF;
   wire st_check = state_q == fpc_pkg::ST_CHECK;
   wire st_write = state_q == fpc_pkg::ST_WRITE;
   wire st_err1  = state_q == fpc_pkg::ST_ERR1;
   wire st_err2  = state_q == fpc_pkg::ST_ERR2;
   wire acc_st   = st_idle | st_write | st_err2;
   wire acc      = hsel_in & htrans_in[1] & hready_in;
   wire dec_go   = (acc_st & acc) | st_check;
   wire pf_take  = st_pref & acc & !pend_q;
   wire fdone    = (st_fetch | st_pref) & (cnt_q == 2'h1);

   // the pending request from a prefetch is replayed from req_q
   assign cur     = st_check ? req_q : {haddr_in, hsize_in, hwrite_in};
   assign lk_tag.rgn  = !cur.addr[`FPC_MAIN_SEL_BIT] ? `FPC_RGN_MAIN :
                        (cur.addr[`FPC_SUB_SEL_BIT] ? `FPC_RGN_SHADOW : `FPC_RGN_TEST); // RL13 RL14
   assign lk_tag.line = cur.addr[`FPC_LINE_LSB +: `FPC_LIDX_W];
   wire   code_bank   = lk_tag.rgn == `FPC_RGN_MAIN;
   wire   bad_rd  = (cur.size > `FPC_SZ_WORD) ||
                    ((cur.size == `FPC_SZ_HALF) && (cur.addr[1:0] == 2'h3)) ||
                    ((cur.size == `FPC_SZ_WORD) && (cur.addr[1:0] != 2'h0)); // RL9
   wire   bad_wr  = (cur.size != `FPC_SZ_WORD) || (cur.addr[1:0] != 2'h0); // RL10
   wire   bad     = cur.write ? bad_wr : bad_rd;
   wire   any_hit = |hit;
   wire   rd_hit  = dec_go & !cur.write & !bad & any_hit;
   wire   rd_miss = dec_go & !cur.write & !bad & !any_hit;

   assign dec0 = ecc_dec(arr_rd_data_in[`FPC_CW_W-1:0]); // RL6
   assign dec1 = ecc_dec(arr_rd_data_in[`FPC_ROW_W-1:`FPC_CW_W]);
   assign row  = {dec1.data, dec0.data}; // RL1
   wire   row_dbe   = dec0.dbe | dec1.dbe;
   wire   row_sbe   = dec0.sbe | dec1.sbe;
   wire   dem_fill  = st_fetch & fdone & !row_dbe & cfg_buf_en_in & (rd_q.tag.rgn == `FPC_RGN_MAIN);
   wire   fill      = dem_fill | (st_pref & fdone & !row_dbe);
   wire   buf_tag_ok = cfg_buf_en_in & code_bank; // RL11
   wire   pf_arm    = cfg_pf_en_in & cfg_buf_en_in & (rd_hit | dem_fill); // RL11 RL12
   wire   pf_launch = st_idle & !acc & pf_q & !(|pf_hitv); // RL12
   assign nxt_tag   = rd_hit ? lk_tag : rd_q.tag;

   genvar gi;
   assign hit_or[0] = '0;
   generate
      for (gi = 0; gi < `FPC_NBUF; gi++)
      begin : g_buf
         assign hit[gi]     = vld_q[gi] & buf_tag_ok & (tag_q[gi] == lk_tag); // RL2
         assign pf_hitv[gi] = vld_q[gi] & (tag_q[gi] == pf_tag_q);
         assign hit_or[gi+1] = hit_or[gi] | (hit[gi] ? data_q[gi] : '0);
      end
   endgenerate

   always_comb
   begin
      hit_idx = 2'h0;
      vic_idx = 2'h0;
      for (int i = `FPC_NBUF - 1; i >= 0; i--)
      begin
         if (hit[i])
            hit_idx = 2'(i);
         if (age_q[i] == 2'h3)
            vic_idx = 2'(i); // RL16
      end
      for (int i = `FPC_NBUF - 1; i >= 0; i--)
         if (!vld_q[i])
            vic_idx = 2'(i);
   end
   assign touch_idx = fill ? vic_idx : hit_idx;

   always_comb
   begin
      state_d = state_q;
      if (dec_go)
      begin
         if (bad)
            state_d = fpc_pkg::ST_ERR1;
         else if (cur.write)
            state_d = fpc_pkg::ST_WRITE;
         else if (any_hit)
            state_d = fpc_pkg::ST_IDLE; // RL3
         else
            state_d = fpc_pkg::ST_FETCH;
      end
      else if (acc_st)
         state_d = pf_launch ? fpc_pkg::ST_PREF : fpc_pkg::ST_IDLE;
      else if (st_fetch & fdone)
         state_d = row_dbe ? fpc_pkg::ST_ERR1 : fpc_pkg::ST_IDLE; // RL15
      else if (st_pref & fdone)
         state_d = (pend_q | pf_take) ? fpc_pkg::ST_CHECK : fpc_pkg::ST_IDLE; // take on last cycle replays too
      else if (st_err1)
         state_d = fpc_pkg::ST_ERR2;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         state_q <= fpc_pkg::ST_IDLE;
         req_q   <= '0;
         rd_q    <= '0;
         wr_q    <= '0;
         cnt_q   <= 2'h0;
         pend_q  <= 1'b0;
         pf_q    <= 1'b0;
         pf_tag_q <= '0;
         err_q   <= 1'b0;
         corr_q  <= 1'b0;
         hrdata_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         if ((acc_st & acc) | pf_take)
            req_q <= cur;
         pend_q <= pf_take | (pend_q & !st_check);
         corr_q <= fdone & row_sbe & !row_dbe; // RL7
         err_q  <= (st_fetch & fdone & row_dbe) | (err_q & !ecc_err_clr_in); // RL15
         if (rd_miss)
         begin
            rd_q  <= {1'b1, lk_tag}; // RL4 RL5
            cnt_q <= WS;
         end
         else if (pf_launch)
         begin
            rd_q  <= {1'b1, pf_tag_q}; // RL12
            cnt_q <= WS;
         end
         else if (fdone)
            rd_q.req <= 1'b0;
         else if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
         if (fdone)
            cnt_q <= 2'h0;
         if (rd_hit)
            hrdata_q <= cur.addr[`FPC_DW_BIT] ? hit_or[`FPC_NBUF][127:64] : hit_or[`FPC_NBUF][63:0]; // RL3
         else if (st_fetch & fdone)
            hrdata_q <= req_q.addr[`FPC_DW_BIT] ? row[127:64] : row[63:0];
         if (pf_arm && (nxt_tag.line != `FPC_LAST_LINE))
         begin
            pf_q     <= 1'b1;
            pf_tag_q <= {nxt_tag.rgn, nxt_tag.line + 16'h0001};
         end
         else if (pf_launch | (st_idle & (|pf_hitv)) | st_write | !cfg_pf_en_in)
            pf_q <= 1'b0;
         wr_q.en <= st_write; // RL8
         if (st_write)
         begin
            wr_q.tag.rgn  <= !req_q.addr[`FPC_MAIN_SEL_BIT] ? `FPC_RGN_MAIN :
                             (req_q.addr[`FPC_SUB_SEL_BIT] ? `FPC_RGN_SHADOW : `FPC_RGN_TEST);
            wr_q.tag.line <= req_q.addr[`FPC_LINE_LSB +: `FPC_LIDX_W];
            wr_q.dword    <= req_q.addr[`FPC_DW_BIT];
            wr_q.wmask    <= req_q.addr[2] ? 2'h2 : 2'h1;
            wr_q.data     <= hwdata_in;
         end
      end
   end

   // buffer contents carry no reset; validity and ages do
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         vld_q <= '0;
         for (int i = 0; i < `FPC_NBUF; i++)
            age_q[i] <= 2'(i);
      end
      else
      begin
         if (st_write)
            vld_q <= '0; // RL16
         else if (fill)
            vld_q[vic_idx] <= 1'b1;
         if (fill | rd_hit)
            for (int i = 0; i < `FPC_NBUF; i++)
               if (2'(i) == touch_idx)
                  age_q[i] <= 2'h0;
               else if (age_q[i] < age_q[touch_idx])
                  age_q[i] <= age_q[i] + 2'h1; // RL16
      end
      if (fill)
      begin
         tag_q[vic_idx]  <= rd_q.tag;
         data_q[vic_idx] <= row; // RL2
      end
   end

   assign hreadyout_out = !(st_fetch | st_err1 | st_check | (st_pref & pend_q));
   assign hresp_out     = st_err1 | st_err2; // RL15
   assign hrdata_out    = hrdata_q;
   assign ecc_err_out   = err_q;
   assign ecc_corr_out  = corr_q;
   assign arr_rd_out    = rd_q;
   assign arr_wr_out    = wr_q;
endmodule // fpc_ctrl

// [verification/fpc_ctrl_monitor.sv]
/* port checker of the flash read controller.
   assumes it is bound into fpc_ctrl and sees its ports only. */
`timescale 1ns/10ps
`include "fpc_cfg.svh"
module fpc_ctrl_monitor (
   // clock and reset
   input wire logic             core_clk_in,
   input wire logic             srst_in,
   // bus side
   input wire logic             hsel_in,
   input wire logic [31:0]      haddr_in,
   input wire logic [1:0]       htrans_in,
   input wire logic             hwrite_in,
   input wire logic [2:0]       hsize_in,
   input wire logic             hready_in,
   input wire logic             hreadyout_out,
   input wire logic             hresp_out,
   // status and array side
   input wire logic             cfg_pf_en_in,
   input wire logic             ecc_err_clr_in,
   input wire logic             ecc_err_out,
   input wire logic             ecc_corr_out,
   input wire fpc_pkg::fpc_rd_t arr_rd_out,
   input wire fpc_pkg::fpc_wr_t arr_wr_out
);
   localparam int WS = `FPC_ARR_WS;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   // only judged when no prefetch can hold the transfer pending
   wire take = hsel_in && htrans_in[1] && hready_in && hreadyout_out && !cfg_pf_en_in;
   wire wr_ok = hwrite_in && hsize_in == `FPC_SZ_WORD && haddr_in[1:0] == 2'h0;
   sequence s_err_pair;
      hresp_out && !hreadyout_out ##1 hresp_out && hreadyout_out;
   endsequence
   AST_ERR_TWO: assert property ($rose(hresp_out) |-> s_err_pair)
      else $error("error response not two cycles");
   AST_ARR_WAIT: assert property ($rose(arr_rd_out.req) |-> ##WS !arr_rd_out.req)
      else $error("array read length wrong");
   AST_MISS_BOUND: assert property (!hreadyout_out && !hresp_out |-> ##[1:8] hreadyout_out)
      else $error("wait states never end");
   AST_RD_ERR: assert property (take && !hwrite_in && hsize_in > `FPC_SZ_WORD |=> s_err_pair)
      else $error("wide read not refused");
   AST_WR_ERR: assert property (take && hwrite_in && !wr_ok |=> s_err_pair)
      else $error("bad write not refused");
   AST_WR_OK: assert property (take && wr_ok |=> hreadyout_out && !hresp_out ##1 arr_wr_out.en &&
      arr_wr_out.wmask == ($past(haddr_in[2], 2) ? 2'h2 : 2'h1))
      else $error("word write not passed on");
   AST_NO_ARR_ON_ERR: assert property (hresp_out |-> !$rose(arr_rd_out.req))
      else $error("array read during error");
   AST_ECC_STICKY: assert property (ecc_err_out && !ecc_err_clr_in |=> ecc_err_out)
      else $error("error flag lost");
   AST_CORR_PULSE: assert property (ecc_corr_out |-> $past(arr_rd_out.req) ##1 !ecc_corr_out)
      else $error("correction pulse wrong");
endmodule // fpc_ctrl_monitor

// [verification/fpc_array_model.sv]
/* behavioural flash array: known row pattern with correct check bytes.
   assumes the bench flips stored bits through flip_in to inject faults. */
`timescale 1ns/10ps
`include "fpc_cfg.svh"
module fpc_array_model (
   // request and fault injection
   input  wire fpc_pkg::fpc_rd_t  arr_rd_in,
   input  wire logic [143:0]      flip_in,
   // row data
   output logic [`FPC_ROW_W-1:0]  arr_rd_data_out
);
   function automatic logic [63:0] word_of(input fpc_pkg::fpc_tag_t t, input logic d);
      return {8'hC3, 5'h00, d, t.rgn, t.line, 16'h0000, ~t.line};
   endfunction
   // hamming over positions 1..71, last bit makes all 72 even
   function automatic logic [7:0] chk_of(input logic [63:0] w);
      logic [71:0] cw;
      int          k;
      cw = '0;
      k = 0;
      chk_of = '0;
      for (int p = 3; p < 72; p++)
         if ((p & (p - 1)) != 0)
         begin
            cw[p] = w[k];
            k++;
         end
      for (int i = 0; i < 7; i++)
         for (int p = 1; p < 72; p++)
            if (p[i])
               chk_of[i] ^= cw[p];
      chk_of[7] = ^{chk_of[6:0], w};
   endfunction
   logic [63:0]  w0;
   logic [63:0]  w1;
   logic [143:0] row;
   assign w0 = word_of(arr_rd_in.tag, 1'b0);
   assign w1 = word_of(arr_rd_in.tag, 1'b1);
   assign row = {chk_of(w1), w1, chk_of(w0), w0} ^ flip_in;
   // released bus shows the inverse so a late sample cannot match
   assign arr_rd_data_out = arr_rd_in.req ? row : ~row;
endmodule // fpc_array_model

// [verification/fpc_ctrl_bench.sv]
/* bench of the flash read controller: bus master tasks, one task per scenario.
   assumes 25 MHz, one array wait state, array model as far side. */
`timescale 1ns/10ps
`include "fpc_cfg.svh"
module fpc_ctrl_bench;
   localparam int WS = `FPC_ARR_WS;
   localparam logic [5:0][35:0] TBL = {36'h100000105, 36'hB00000100, 36'hA00000102, 36'h90000010B, 36'h10000010A,
      36'h000000103};
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, buf_en = 1'b1, pf_en = 1'b0, clr = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic [63:0] hwdata = '0, hrdata, rd;
   logic [143:0] flip = '0, rd_data;
   logic hreadyout, hresp, ecc_err, ecc_corr, rsp;
   logic [1:0] rgn_seen;
   fpc_pkg::fpc_rd_t arr_rd;
   fpc_pkg::fpc_wr_t arr_wr, wr_seen;
   int err_total = 0, n_tests = 0, n_rd = 0, n_corr = 0, n_wr = 0, ws;
   always #20 core_clk_in = ~core_clk_in;
   fpc_ctrl dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
      .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .cfg_buf_en_in(buf_en),
      .cfg_pf_en_in(pf_en), .ecc_err_clr_in(clr), .ecc_err_out(ecc_err), .ecc_corr_out(ecc_corr),
      .arr_rd_out(arr_rd), .arr_rd_data_in(rd_data), .arr_wr_out(arr_wr));
   fpc_array_model u_arr (.arr_rd_in(arr_rd), .flip_in(flip), .arr_rd_data_out(rd_data));
   always @(posedge arr_rd.req)
   begin
      n_rd++;
      rgn_seen = arr_rd.tag.rgn;
   end
   always @(posedge ecc_corr) n_corr++;
   always @(posedge core_clk_in)
      if (arr_wr.en === 1'b1)
      begin
         n_wr++;
         wr_seen <= arr_wr;
      end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_rdy(output int n);
      n = 0;
      @(negedge core_clk_in);
      while (hreadyout !== 1'b1 && n < 40)
      begin
         n++;
         @(negedge core_clk_in);
      end
      rd = hrdata;
      rsp = hresp;
      check(64'(n < 40), 64'h1);
      @(posedge core_clk_in);
   endtask
   task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [63:0] wd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      wait_rdy(n);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(ws);
   endtask
   task automatic rd_chk(input logic [31:0] a, input int exp_ws);
      xfer(a, 1'b0, `FPC_SZ_WORD, 64'h0);
      check(rsp, 1'b0);
      check(rd, u_arr.word_of('{2'h0, a[19:4]}, a[3]));
      check(64'(ws), 64'(exp_ws));
   endtask
   task automatic t_hit_miss();
      int k;
      k = n_rd;
      rd_chk(32'h100, WS);
      rd_chk(32'h108, 0);
      check(64'(n_rd - k), 64'h1);
   endtask
   task automatic t_lru();
      for (int i = 0; i < 8; i++)
         rd_chk(32'h2000 + 32'(i % 4) * 32'h10, (i < 4) ? WS : 0);
      rd_chk(32'h2040, WS);
      rd_chk(32'h2030, 0);
      rd_chk(32'h2000, WS);
   endtask
   task automatic t_size();
      for (int i = 0; i < 6; i++)
      begin
         xfer(TBL[i][31:0], 1'b0, TBL[i][34:32], 64'h0);
         check(rsp, TBL[i][35]);
         if (!TBL[i][35])
            check(rd, u_arr.word_of('{2'h0, TBL[i][19:4]}, TBL[i][3]));
      end
   endtask
   task automatic t_write();
      int k;
      k = n_wr;
      xfer(32'h104, 1'b1, `FPC_SZ_WORD, {2{32'h5AC30F96}});
      repeat (2) @(posedge core_clk_in);
      check(rsp, 1'b0);
      check({wr_seen.wmask, wr_seen.tag.line}, {2'h2, 16'h0010});
      check(wr_seen.data[63:32], 32'h5AC30F96);
      xfer(32'h102, 1'b1, `FPC_SZ_WORD, 64'h0);
      check(rsp, 1'b1);
      xfer(32'h100, 1'b1, `FPC_SZ_HALF, 64'h0);
      check(rsp, 1'b1);
      check(64'(n_wr - k), 64'h1);
      rd_chk(32'h100, WS);
   endtask
   task automatic t_pref();
      pf_en <= 1'b1;
      rd_chk(32'h3000, WS);
      repeat (6) @(posedge core_clk_in);
      rd_chk(32'h3010, 0);
      // taken while the next-line fetch runs, so it waits and then hits the fetched line
      rd_chk(32'h3020, WS);
      pf_en <= 1'b0;
      buf_en <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      rd_chk(32'h4000, WS);
      rd_chk(32'h4008, WS);
      buf_en <= 1'b1;
   endtask
   task automatic t_ecc();
      int k;
      k = n_corr;
      flip <= 144'h1 << 77;
      rd_chk(32'h5000, WS);
      flip <= (144'h1 << 140) | (144'h1 << 9);
      rd_chk(32'h5018, WS);
      check(64'(n_corr - k), 64'h2);
      flip <= 144'h3 << 20;
      xfer(32'h6000, 1'b0, `FPC_SZ_WORD, 64'h0);
      check(rsp, 1'b1);
      flip <= '0;
      repeat (3) @(posedge core_clk_in);
      check(ecc_err, 1'b1);
      clr <= 1'b1;
      @(posedge core_clk_in);
      clr <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      check(ecc_err, 1'b0);
      rd_chk(32'h6000, WS);
   endtask
   task automatic t_region();
      xfer(32'h00100040, 1'b0, `FPC_SZ_WORD, 64'h0);
      check({rsp, rgn_seen}, 3'h1);
      xfer(32'h00104040, 1'b0, `FPC_SZ_WORD, 64'h0);
      check({rsp, rgn_seen}, 3'h2);
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk_in);
      srst_in <= 1'b0;
      @(posedge core_clk_in);
      t_hit_miss();
      t_lru();
      t_size();
      t_write();
      t_pref();
      t_ecc();
      t_region();
      print_verdict();
   end
   initial
   begin
      repeat (4000) @(posedge core_clk_in);
      err_total++;
      print_verdict();
   end
endmodule // fpc_ctrl_bench
bind fpc_ctrl fpc_ctrl_monitor u_mon (.*);
